// file: hdl/pcf_core.v
// Notes on behaviour
// - The core drives the active-low read final-beat flag low after the final-datum pulse and holds it until the fabric loads the next datum.
// - With burst pending asserted and the read buffer empty the core inserts wait states up to a maximum, then disconnects.
// - The core forwards the active-low fabric interrupt request onto the bus interrupt line.
// - The core gives the fabric a copy of the bus clock, synchronous to it.
// - The core asserts the forwarded active-low reset once the bus reset line has been sampled asserted on two successive clocks.
// - The fabric drives the system error request on the PCI clock and the core passes it onto the bus error line.
// - The core raises the wide-bus flag when the 64-bit request line is low at the rising edge of bus reset.
// - The wide-bus flag says nothing about the width of any single transaction.
`include "pcf_core_defs.vh"

module pcf_core (
  input  wire                   clk,               // PCI clock, 40 MHz
  input  wire                   rst_b,             // Asynchronous reset, active low
  // Bus pins
  input  wire                   bus_rst_b_pin,     // Bus reset line, asynchronous
  input  wire                   bus_req64_b_pin,   // Bus 64-bit request line, asynchronous
  output reg                    bus_inta_o,        // Interrupt line drive value
  output reg                    bus_inta_oe,       // Interrupt line enable, high while pulled low
  output reg                    bus_serr_o,        // System error line drive value
  output reg                    bus_serr_oe,       // System error line enable, high while pulled low
  // Bus-side read engine
  input  wire                   bus_rd_want,       // Engine needs a read datum this cycle
  input  wire                   bus_rd_final,      // Pulse: the operation needs just one more datum
  output reg                    bus_rd_valid,      // Buffered datum available
  output reg [`PCF_DATA_W-1:0]  bus_rd_data,       // Buffered datum
  input  wire                   bus_rd_ready,      // Engine takes the datum
  output reg                    bus_rd_wait,       // Insert a wait state
  output reg                    bus_rd_disc,       // Pulse: disconnect the target read
  // Fabric target read side
  input  wire                   rd_load_b,         // Load strobe, active low
  input  wire [`PCF_DATA_W-1:0] rd_load_data,      // Datum to load
  output reg                    rd_full_b,         // Read buffer full, active low
  output reg                    rd_empty_b,        // Read buffer empty, active low
  output reg                    rd_last_b,         // Final-beat flag, active low
  input  wire                   rd_burst_pend_b,   // Burst pending, active low
  // Fabric miscellaneous
  input  wire                   fab_irq_b,         // Interrupt request, active low
  input  wire                   fab_sys_err,       // System error request, active high
  output wire                   fab_clk_copy,      // Copy of the bus clock
  output reg                    fab_rst_b,         // Forwarded bus reset, active low
  output reg                    wide_bus_detected, // Attached as a 64-bit agent
  input  wire                   fifo_sel,          // Dual-port path select
  input  wire [`PCF_DATA_W-1:0] mst_rd_data,       // Master read data
  input  wire [`PCF_DATA_W-1:0] tgt_wr_data,       // Target write data
  output reg [`PCF_DATA_W-1:0]  fab_path_data      // Selected return data
);

  localparam [2:0] ST_IDLE = 3'b001;
  localparam [2:0] ST_WAIT = 3'b010;
  localparam [2:0] ST_DISC = 3'b100;

  reg [2:0]               rst_sync_r;
  reg [2:0]               req64_sync_r;
  reg                     rst_seen_r;
  reg                     req64_seen_r;
  reg [`PCF_DATA_W-1:0]   tail_r;
  reg                     tail_ok_r;
  reg [1:0]               cnt_nxt;
  reg                     last_pend_r;
  reg [2:0]               st_r;
  reg [2:0]               st_nxt;
  reg [`PCF_WAIT_W-1:0]   wait_cnt_r;
  reg [`PCF_WAIT_W-1:0]   wait_cnt_nxt;
  wire                    push;
  wire                    pop;
  wire                    head_ok_nxt;
  wire                    tail_ok_nxt;
  wire                    rst_lvl;
  wire                    req64_lvl;

  ////////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers; a change counts once stages two and three agree

  always @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rst_sync_r   <= 3'h0;
      req64_sync_r <= 3'h7;
    end
    else
    begin
      rst_sync_r   <= {rst_sync_r[1:0], bus_rst_b_pin};
      req64_sync_r <= {req64_sync_r[1:0], bus_req64_b_pin};
    end
  end

  assign rst_lvl   = (rst_sync_r[2] == rst_sync_r[1]) ? rst_sync_r[2] : rst_seen_r;
  assign req64_lvl = (req64_sync_r[2] == req64_sync_r[1]) ? req64_sync_r[2] : req64_seen_r;

  ////////////////////////////////////////////////////////////////////////////////
  // Reset forwarding and wide-bus capture

  always @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rst_seen_r        <= 1'b0;
      req64_seen_r      <= 1'b1;
      fab_rst_b         <= 1'b0;
      wide_bus_detected <= `PCF_RST_WIDE;
    end
    else
    begin
      rst_seen_r   <= rst_lvl;
      req64_seen_r <= req64_lvl;
      fab_rst_b    <= rst_lvl;
      if (rst_lvl && !rst_seen_r)
        wide_bus_detected <= ~req64_lvl;
    end
  end

  assign fab_clk_copy = clk;

  ////////////////////////////////////////////////////////////////////////////////
  // Interrupt, system error and dual-port return path

  always @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      bus_inta_o    <= 1'b0;
      bus_inta_oe   <= 1'b0;
      bus_serr_o    <= 1'b0;
      bus_serr_oe   <= 1'b0;
      fab_path_data <= {`PCF_DATA_W{1'b0}};
    end
    else
    begin
      bus_inta_o  <= 1'b0;
      bus_inta_oe <= ~fab_irq_b;
      bus_serr_o  <= 1'b0;
      bus_serr_oe <= fab_sys_err;
      if (fifo_sel == `PCF_SEL_TGT_WRITE)
        fab_path_data <= tgt_wr_data;
      else
        fab_path_data <= mst_rd_data;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Two-entry read buffer; head is the output register

  // A load while full is dropped
  assign push        = ~rd_load_b & ~(bus_rd_valid & tail_ok_r);
  assign pop         = bus_rd_valid & bus_rd_ready;
  assign head_ok_nxt = tail_ok_r | push | (bus_rd_valid & ~pop);
  assign tail_ok_nxt = (tail_ok_r & ~pop) | (push & bus_rd_valid & ~pop) | (push & tail_ok_r);

  always @*
  begin
    cnt_nxt = {1'b0, head_ok_nxt} + {1'b0, tail_ok_nxt};
  end

  always @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      bus_rd_valid <= 1'b0;
      bus_rd_data  <= {`PCF_DATA_W{1'b0}};
      tail_r       <= {`PCF_DATA_W{1'b0}};
      tail_ok_r    <= 1'b0;
      rd_full_b    <= 1'b1;
      rd_empty_b   <= 1'b0;
    end
    else
    begin
      if (!bus_rd_valid || pop)
      begin
        if (tail_ok_r)
          bus_rd_data <= tail_r;
        else if (push)
          bus_rd_data <= rd_load_data;
      end
      if (push && bus_rd_valid && !(pop && !tail_ok_r))
        tail_r <= rd_load_data;
      bus_rd_valid <= head_ok_nxt;
      tail_ok_r    <= tail_ok_nxt;
      rd_full_b    <= ~(cnt_nxt == 2'h2);
      rd_empty_b   <= ~(cnt_nxt == 2'h0);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Final-beat flag: held low until the fabric loads the last datum

  always @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      last_pend_r <= 1'b0;
      rd_last_b   <= `PCF_RST_LAST_B;
    end
    else
    begin
      if (bus_rd_final)
      begin
        last_pend_r <= 1'b1;
        rd_last_b   <= 1'b0;
      end
      else if (push && last_pend_r)
      begin
        last_pend_r <= 1'b0;
        rd_last_b   <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Wait-state control on an empty read buffer

  always @*
  begin
    st_nxt       = st_r;
    wait_cnt_nxt = wait_cnt_r;
    case (st_r)
      ST_IDLE:
      begin
        wait_cnt_nxt = {`PCF_WAIT_W{1'b0}};
        if (bus_rd_want && !head_ok_nxt)
        begin
          if (!rd_burst_pend_b)
            st_nxt = ST_WAIT;
          else
            st_nxt = ST_DISC;
        end
      end
      ST_WAIT:
      begin
        if (head_ok_nxt || !bus_rd_want)
          st_nxt = ST_IDLE;
        else if (wait_cnt_r == `PCF_WAIT_MAX - 4'h1)
          st_nxt = ST_DISC;
        else
          wait_cnt_nxt = wait_cnt_r + 4'h1;
      end
      ST_DISC:
        st_nxt = ST_IDLE;
      default:
        st_nxt = ST_IDLE;
    endcase
  end

  always @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      st_r        <= ST_IDLE;
      wait_cnt_r  <= {`PCF_WAIT_W{1'b0}};
      bus_rd_wait <= 1'b0;
      bus_rd_disc <= 1'b0;
    end
    else
    begin
      st_r        <= st_nxt;
      wait_cnt_r  <= wait_cnt_nxt;
      bus_rd_wait <= (st_nxt == ST_WAIT);
      bus_rd_disc <= (st_nxt == ST_DISC);
    end
  end

endmodule

// file: hdl/pcf_core_defs.vh
`ifndef PCF_CORE_DEFS_VH
`define PCF_CORE_DEFS_VH

// Data path width of the target read path and of the dual-port return path
`define PCF_DATA_W        32
// Entries in the target read buffer
`define PCF_BUF_DEPTH     2
// Most bus wait states inserted on an empty buffer before disconnecting
`define PCF_WAIT_MAX      4'h8
`define PCF_WAIT_W        4
// Values of the dual-port path select
`define PCF_SEL_MST_READ  1'b0
`define PCF_SEL_TGT_WRITE 1'b1
// Reset values
`define PCF_RST_LAST_B    1'b1
`define PCF_RST_WIDE      1'b0

`endif

// file: verification/pcf_core_sva.sv
module pcf_core_sva (
  input wire logic        clk,             // PCI clock
  input wire logic        rst_b,           // Reset, active low
  input wire logic        bus_rst_b_pin,   // Bus reset line
  input wire logic        bus_inta_oe,     // Interrupt line enable
  input wire logic        bus_serr_oe,     // Error line enable
  input wire logic        fab_irq_b,       // Interrupt request
  input wire logic        fab_sys_err,     // Error request
  input wire logic        fifo_sel,        // Path select
  input wire logic        fab_rst_b,       // Forwarded reset
  input wire logic        rd_last_b,       // Final-beat flag
  input wire logic        bus_rd_final,    // Final datum request
  input wire logic        rd_load_b,       // Load strobe
  input wire logic        rd_full_b,       // Buffer full
  input wire logic        bus_rd_want,     // Engine wants data
  input wire logic        bus_rd_valid,    // Head valid
  input wire logic        rd_burst_pend_b, // Burst pending
  input wire logic        bus_rd_wait,     // Wait state
  input wire logic        bus_rd_disc,     // Disconnect
  input wire logic [31:0] mst_rd_data,     // Master read data
  input wire logic [31:0] tgt_wr_data,     // Target write data
  input wire logic [31:0] fab_path_data    // Selected data
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  sequence s_want;
    $rose(bus_rd_want) && !bus_rd_valid && rd_load_b;
  endsequence
  sequence s_wait8;
    (bus_rd_wait && bus_rd_want && rd_load_b)[*8];
  endsequence
  property p_irq; 1 |=> bus_inta_oe == !$past(fab_irq_b); endproperty
  property p_serr; 1 |=> bus_serr_oe == $past(fab_sys_err); endproperty
  property p_path; 1 |=> fab_path_data == ($past(fifo_sel) ? $past(tgt_wr_data) : $past(mst_rd_data)); endproperty
  property p_last_set; bus_rd_final |=> !rd_last_b; endproperty
  property p_last_clr; !rd_last_b && !rd_load_b && rd_full_b && !bus_rd_final |=> rd_last_b; endproperty
  property p_pend_wait; s_want ##0 !rd_burst_pend_b |=> bus_rd_wait && !bus_rd_disc; endproperty
  property p_wait_max; s_wait8 |=> bus_rd_disc && !bus_rd_wait; endproperty
  property p_no_pend; s_want ##0 rd_burst_pend_b |=> bus_rd_disc && !bus_rd_wait; endproperty
  property p_disc_once; bus_rd_disc |=> !bus_rd_disc; endproperty
  property p_rst_fwd; !bus_rst_b_pin [*5] |-> !fab_rst_b; endproperty
  a_irq: assert property (p_irq) else $error("interrupt enable wrong");
  a_serr: assert property (p_serr) else $error("error enable wrong");
  a_path: assert property (p_path) else $error("path data wrong");
  a_last_set: assert property (p_last_set) else $error("final flag not set");
  a_last_clr: assert property (p_last_clr) else $error("final flag not cleared");
  a_pend_wait: assert property (p_pend_wait) else $error("no wait state");
  a_wait_max: assert property (p_wait_max) else $error("wait limit wrong");
  a_no_pend: assert property (p_no_pend) else $error("no disconnect");
  a_disc_once: assert property (p_disc_once) else $error("disconnect too long");
  a_rst_fwd: assert property (p_rst_fwd) else $error("reset not forwarded");
endmodule

// file: verification/pcf_fabric_model.sv
module pcf_fabric_model (
  input  wire logic   clk,         // Fabric copy of bus clock, one clock for both FIFOs
  input  wire logic   en,          // Stall control
  input  wire logic   rd_full_b,   // Buffer full
  input  wire logic   rd_last_b,   // Final-beat flag
  output logic        rd_load_b,   // Load strobe
  output logic [31:0] rd_load_data // Datum, equal to its address
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [31:0] addr = 32'h00001000;
  logic        done = 1'b0;
  logic        go = 1'b0;
  initial rd_load_b = 1'b1;
  initial rd_load_data = 32'h0;
  // Stall control taken at the edge, clear of the bench's own drive
  always @(posedge clk)
  begin
    go = en;
    #1;
    if (!rd_load_b)
      addr = addr + 32'h4;
    rd_load_b = !(go && rd_full_b && !done);
    done = done | (!rd_load_b && !rd_last_b);
    rd_load_data = rd_load_b ? ~addr : addr;
  end
endmodule

// file: verification/tb_top.sv
bind pcf_core pcf_core_sva chk_i (.clk(clk), .rst_b(rst_b), .bus_rst_b_pin(bus_rst_b_pin),
  .bus_inta_oe(bus_inta_oe), .bus_serr_oe(bus_serr_oe), .fab_irq_b(fab_irq_b), .fab_sys_err(fab_sys_err),
  .fifo_sel(fifo_sel), .fab_rst_b(fab_rst_b), .rd_last_b(rd_last_b), .bus_rd_final(bus_rd_final),
  .rd_load_b(rd_load_b), .rd_full_b(rd_full_b), .bus_rd_want(bus_rd_want), .bus_rd_valid(bus_rd_valid),
  .rd_burst_pend_b(rd_burst_pend_b), .bus_rd_wait(bus_rd_wait), .bus_rd_disc(bus_rd_disc),
  .mst_rd_data(mst_rd_data), .tgt_wr_data(tgt_wr_data), .fab_path_data(fab_path_data));
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 0, rst_b = 0, bus_rst_b_pin = 0, bus_req64_b_pin = 0, bus_rd_want = 0, load_en = 0;
  logic bus_rd_final = 0, bus_rd_ready = 0, rd_burst_pend_b = 1, fab_irq_b = 1, fab_sys_err = 0;
  logic fifo_sel = 0, bus_inta_o, bus_inta_oe, bus_serr_o, bus_serr_oe, bus_rd_valid, bus_rd_wait;
  logic bus_rd_disc, rd_load_b, rd_full_b, rd_empty_b, rd_last_b, fab_clk_copy, fab_rst_b;
  logic wide_bus_detected;
  logic [31:0] mst_rd_data = 0, tgt_wr_data = 0, bus_rd_data, rd_load_data, fab_path_data, e;
  logic [31:0] seed = 11, nxt = 32'h00001000;
  int fails = 0, checked = 0, cyc = 0, cnt = 0, n;
  pcf_core DUT (.clk(clk), .rst_b(rst_b), .bus_rst_b_pin(bus_rst_b_pin), .bus_req64_b_pin(bus_req64_b_pin),
    .bus_inta_o(bus_inta_o), .bus_inta_oe(bus_inta_oe), .bus_serr_o(bus_serr_o), .bus_serr_oe(bus_serr_oe),
    .bus_rd_want(bus_rd_want), .bus_rd_final(bus_rd_final), .bus_rd_valid(bus_rd_valid),
    .bus_rd_data(bus_rd_data), .bus_rd_ready(bus_rd_ready), .bus_rd_wait(bus_rd_wait),
    .bus_rd_disc(bus_rd_disc), .rd_load_b(rd_load_b), .rd_load_data(rd_load_data), .rd_full_b(rd_full_b),
    .rd_empty_b(rd_empty_b), .rd_last_b(rd_last_b), .rd_burst_pend_b(rd_burst_pend_b),
    .fab_irq_b(fab_irq_b), .fab_sys_err(fab_sys_err), .fab_clk_copy(fab_clk_copy), .fab_rst_b(fab_rst_b),
    .wide_bus_detected(wide_bus_detected), .fifo_sel(fifo_sel), .mst_rd_data(mst_rd_data),
    .tgt_wr_data(tgt_wr_data), .fab_path_data(fab_path_data));
  // Looped-back bus clock serves as the single FIFO clock
  pcf_fabric_model fab (.clk(fab_clk_copy), .en(load_en), .rd_full_b(rd_full_b), .rd_last_b(rd_last_b),
    .rd_load_b(rd_load_b), .rd_load_data(rd_load_data));
  always #12.5 clk = ~clk;
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      fails++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic tick(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  task automatic finish_test();
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 2000)
    begin
      fails++;
      finish_test();
    end
  end
  // Buffer model: occupancy and expected datum order
  always @(posedge clk)
    if (rst_b)
    begin
      chk(rd_empty_b, cnt != 0);
      chk(rd_full_b, cnt != 2);
      chk(bus_rd_valid, cnt != 0);
      if (bus_rd_valid && bus_rd_ready)
      begin
        chk(bus_rd_data, nxt);
        nxt += 4;
        cnt--;
      end
      cnt += !rd_load_b;
    end
  initial
  begin
    tick(12);
    rst_b = 1;
    tick(6);
    chk(fab_rst_b, 0);
    bus_rst_b_pin = 1;
    tick(8);
    chk(fab_rst_b, 1);
    chk(wide_bus_detected, 1);
    chk(fab_clk_copy, 1);
    bus_req64_b_pin = 1;
    #13;
    chk(fab_clk_copy, 0);
    tick(8);
    chk(wide_bus_detected, 1);
    bus_rst_b_pin = 0;
    tick(6);
    chk(fab_rst_b, 0);
    chk(wide_bus_detected, 1);
    bus_rst_b_pin = 1;
    tick(8);
    chk(fab_rst_b, 1);
    chk(wide_bus_detected, 0);
    bus_req64_b_pin = 0;
    tick(8);
    chk(wide_bus_detected, 0);
    $display("test reset done");
    repeat (40)
    begin
      e = rnd();
      fab_irq_b = e[0];
      fab_sys_err = e[1];
      fifo_sel = e[2];
      mst_rd_data = rnd();
      tgt_wr_data = rnd();
      tick(1);
      chk({bus_inta_oe, bus_inta_o, bus_serr_oe, bus_serr_o}, {!e[0], 1'b0, e[1], 1'b0});
      chk(fab_path_data, e[2] ? tgt_wr_data : mst_rd_data);
      tick(1);
    end
    $display("test sideband done");
    repeat (60)
    begin
      e = rnd();
      bus_rd_ready = e[0] & e[1];
      load_en = e[2] | e[3];
      tick(1);
    end
    load_en = 0;
    bus_rd_ready = 1;
    tick(4);
    load_en = 1;
    bus_rd_final = 1;
    tick(1);
    bus_rd_final = 0;
    chk(rd_last_b, 0);
    tick(6);
    chk({rd_last_b, rd_load_b, bus_rd_valid}, 3'b110);
    $display("test stream done");
    rd_burst_pend_b = 0;
    bus_rd_want = 1;
    for (n = 0; n < 20 && !bus_rd_disc; n++)
      tick(1);
    chk(n, 9);
    bus_rd_want = 0;
    tick(2);
    rd_burst_pend_b = 1;
    bus_rd_want = 1;
    for (n = 0; n < 20 && !bus_rd_disc; n++)
      tick(1);
    chk(n, 1);
    bus_rd_want = 0;
    tick(2);
    $display("test wait done");
    finish_test();
  end
endmodule
